//--- sfc_pkg.sv
// shared constants for the serial frame crc checker link, both ends
package sfc_pkg;
  // clock and link timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_HALF_NS  = 80;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W         = 8;
  // frame lengths
  localparam logic [4:0] BASIC_BITS = 5'h10;
  localparam logic [4:0] FRAME_BITS = 5'h18;
  // check sequence x^8+x^2+x+1, msb first, cleared to zero
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // device word layout
  localparam int         WORD_W         = 16;
  localparam int         CTRL_W         = 13;
  localparam logic [2:0] ADDR_CTRL      = 3'h0;
  localparam logic [2:0] ADDR_RDSTAT    = 3'h1;
  localparam logic [12:0] CTRL_RST      = 13'h0000;
  localparam int         CTRL_RANGE_LSB = 7;
  localparam int         RANGE_W        = 4;
  localparam int         RANGE_OVR_BIT  = 3;
  localparam int         RANGE_CUR_BIT  = 2;
  localparam logic [1:0] CUR_BIPOLAR_IDX = 2'h3;
  // status flag positions in the read word
  localparam int ST_CRC   = 3;
  localparam int ST_TEMP  = 2;
  localparam int ST_OPEN  = 1;
  localparam int ST_SHORT = 0;
  // output span in percent of nominal
  localparam int         PCT_W          = 8;
  localparam logic [7:0] SPAN_NORM_PCT  = 8'h64;
  localparam logic [7:0] SPAN_VOLT_PCT  = 8'h78;
  localparam logic [7:0] SPAN_CURR_PCT  = 8'h66;
  // host wishbone map, byte addresses
  localparam int         WB_ADR_W  = 4;
  localparam logic [3:0] REG_CMD   = 4'h0;
  localparam logic [3:0] REG_STAT  = 4'h4;
  localparam logic [3:0] REG_IRQ   = 4'h8;
  localparam logic [3:0] REG_MASK  = 4'hC;
  localparam int         CMD_CRC_BIT = 16;
  localparam int         CMD_GO_BIT  = 31;
  localparam int         IRQ_DONE    = 0;
  localparam int         IRQ_ALERT   = 1;
endpackage

//--- sfc_link_if.sv
// three-wire link plus readback line and open-drain alert between host and device
`timescale 1ns/100ps
`default_nettype none
interface sfc_link_if;
  logic sclk;
  logic sdi;
  logic sync_n;
  logic sdo;
  logic alert_drv;
  logic alert_oe;
  logic alert;
  // pull-up wins while nobody pulls the shared alert wire
  assign alert = alert_oe ? alert_drv : 1'b1;
  modport dev  (input sclk, input sdi, input sync_n, output sdo, output alert_drv, output alert_oe);
  modport host (output sclk, output sdi, output sync_n, input sdo, input alert);
endinterface
`default_nettype wire

//--- sfc_crc8.sv
// serial crc-8 accumulator, one bit per shift strobe
`timescale 1ns/100ps
`default_nettype none
module sfc_crc8 (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       clear_i,
  input  wire logic       shift_i,
  input  wire logic       bit_i,
  output logic      [7:0] crc_o
);
  import sfc_pkg::*;
  logic [7:0] next_crc;

  // clear beats shift so a new frame always starts from the seed
  always_comb begin
    next_crc = crc_o;
    if (clear_i) begin
      next_crc = CRC_INIT;
    end else if (shift_i) begin
      next_crc = {crc_o[6:0], 1'b0} ^ ((crc_o[7] ^ bit_i) ? CRC_POLY : 8'h00);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_o <= CRC_INIT;
    end else if (ce_i) begin
      crc_o <= next_crc;
    end
  end
endmodule
`default_nettype wire

//--- sfc_dev.sv
// device end: frame receiver, crc check, control register, status readback, fault alert, range decode
`timescale 1ns/100ps
`default_nettype none
module sfc_dev (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        ce_i,
  sfc_link_if.dev                          link,
  input  wire logic                        hw_mode_i,
  input  wire logic [sfc_pkg::RANGE_W-1:0] range_pins_i,
  input  wire logic                        over_temp_i,
  input  wire logic                        current_open_i,
  input  wire logic                        voltage_short_i,
  output logic      [sfc_pkg::CTRL_W-1:0]  ctrl_o,
  output logic      [sfc_pkg::RANGE_W-1:0] range_sel_o,
  output logic                             ovr_volt_o,
  output logic                             ovr_curr_o,
  output logic      [sfc_pkg::PCT_W-1:0]   span_pct_o,
  output logic                             frame_ok_o,
  output logic                             crc_err_o
);
  import sfc_pkg::*;

  // synchroniser lanes: all of these arrive from outside the clock domain
  localparam int          S_SCLK  = 0;
  localparam int          S_SDI   = 1;
  localparam int          S_SYNC  = 2;
  localparam int          S_TEMP  = 3;
  localparam int          S_OPEN  = 4;
  localparam int          S_SHORT = 5;
  localparam int          S_HW    = 6;
  localparam int          S_PINS  = 7;
  localparam int          SYNC_W  = 11;
  localparam logic [10:0] SYNC_RST = 11'h004;

  logic [SYNC_W-1:0] meta;
  logic [SYNC_W-1:0] pin;
  logic              sclk_prev;
  logic              sync_prev;
  logic [SYNC_W-1:0] pin_raw;

  logic [23:0]       shreg;
  logic [4:0]        cnt;
  logic              crc_flag;
  logic              rd_pend;
  logic              rd_act;
  logic [15:0]       out_sh;
  logic              sdo_q;
  logic              alert_oe_q;
  logic [7:0]        crc_val;

  logic [23:0]       next_shreg;
  logic [4:0]        next_cnt;
  logic [CTRL_W-1:0] next_ctrl;
  logic              next_crc_flag;
  logic              next_rd_pend;
  logic              next_rd_act;
  logic [15:0]       next_out_sh;
  logic              next_sdo;
  logic              next_alert_oe;
  logic [RANGE_W-1:0] next_range;
  logic              next_ovr_volt;
  logic              next_ovr_curr;
  logic [PCT_W-1:0]  next_span;
  logic              next_frame_ok;
  logic              next_crc_err;

  logic              fall;
  logic              in_frame;
  logic              frame_start;
  logic              frame_end;
  logic              crc_shift;
  logic [15:0]       data_word;
  logic              crc_ok;
  logic              good;
  logic              bad;
  logic [3:0]        flags;
  logic [15:0]       status_word;

  assign pin_raw = {range_pins_i, hw_mode_i, voltage_short_i, current_open_i, over_temp_i,
                    link.sync_n, link.sdi, link.sclk};

  // two flops per lane, the second one is the only reader of the first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta      <= SYNC_RST;
      pin       <= SYNC_RST;
      sclk_prev <= 1'b0;
      sync_prev <= 1'b1;
    end else if (ce_i) begin
      meta      <= pin_raw;
      pin       <= meta;
      sclk_prev <= pin[S_SCLK];
      sync_prev <= pin[S_SYNC];
    end
  end

  // link events, all taken from the synchronised copies
  assign fall        = sclk_prev & ~pin[S_SCLK];
  assign in_frame    = ~pin[S_SYNC];
  assign frame_start = sync_prev & ~pin[S_SYNC];
  assign frame_end   = ~sync_prev & pin[S_SYNC];
  assign crc_shift   = fall & in_frame & (cnt < BASIC_BITS);

  // check sequence runs over the first sixteen bits only
  sfc_crc8 u_crc (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .clear_i (frame_start),
    .shift_i (crc_shift),
    .bit_i   (pin[S_SDI]),
    .crc_o   (crc_val)
  );

  // frame verdict at select rising; a 16-bit word carries no check byte
  assign data_word   = (cnt == FRAME_BITS) ? shreg[23:8] : shreg[15:0];
  assign crc_ok      = (shreg[7:0] == crc_val);
  assign good        = (cnt == BASIC_BITS) | ((cnt == FRAME_BITS) & crc_ok);
  assign bad         = (cnt == FRAME_BITS) & ~crc_ok;
  assign flags       = {crc_flag, pin[S_TEMP], pin[S_OPEN], pin[S_SHORT]};
  assign status_word = {ADDR_RDSTAT, ctrl_o[CTRL_W-1:4], flags};

  // receiver, register file, readback and fault state
  always_comb begin
    next_shreg    = shreg;
    next_cnt      = cnt;
    next_ctrl     = ctrl_o;
    next_crc_flag = crc_flag;
    next_rd_pend  = rd_pend;
    next_rd_act   = rd_act;
    next_out_sh   = out_sh;
    next_sdo      = sdo_q;
    next_frame_ok = 1'b0;
    next_crc_err  = 1'b0;
    if (frame_start) begin
      next_cnt = 5'h00;
      if (rd_pend) begin
        next_out_sh  = status_word;
        next_sdo     = status_word[15];
        next_rd_act  = 1'b1;
        next_rd_pend = 1'b0;
      end
    end else if (fall & in_frame) begin
      next_shreg = {shreg[22:0], pin[S_SDI]};
      next_cnt   = (cnt == 5'h1F) ? cnt : 5'(cnt + 5'h01);     // longer frames saturate and are dropped without an error
      if (rd_act) begin
        next_out_sh = {out_sh[14:0], 1'b0};
        next_sdo    = out_sh[14];
      end
    end else if (frame_end) begin
      next_rd_act = 1'b0;
      next_sdo    = 1'b0;
      // the readback word counts as read only once all sixteen bits went out
      if (rd_act & (cnt >= BASIC_BITS)) begin
        next_crc_flag = 1'b0;
      end
      if (good) begin
        next_frame_ok = 1'b1;
        unique case (data_word[15:13])
          ADDR_CTRL:   next_ctrl    = data_word[CTRL_W-1:0];
          ADDR_RDSTAT: next_rd_pend = 1'b1;
          default:     next_ctrl    = ctrl_o;                   // unmapped address is dropped
        endcase
      end
      // a failed frame touches nothing but the error flag; setting beats the read clear
      if (bad) begin
        next_crc_flag = 1'b1;
        next_crc_err  = 1'b1;
      end
    end
  end

  // alert and range decode; hardware mode takes the range from the pins
  always_comb begin
    next_alert_oe = ~pin[S_HW] & (crc_flag | pin[S_TEMP] | pin[S_OPEN] | pin[S_SHORT]);
    next_range    = pin[S_HW] ? pin[S_PINS +: RANGE_W] : ctrl_o[CTRL_RANGE_LSB +: RANGE_W];
    next_ovr_volt = next_range[RANGE_OVR_BIT] & ~next_range[RANGE_CUR_BIT];
    // the bipolar current range has no overrange variant
    next_ovr_curr = next_range[RANGE_OVR_BIT] & next_range[RANGE_CUR_BIT]
                    & (next_range[1:0] != CUR_BIPOLAR_IDX);
    next_span     = next_ovr_volt ? SPAN_VOLT_PCT : (next_ovr_curr ? SPAN_CURR_PCT : SPAN_NORM_PCT);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shreg       <= 24'h000000;
      cnt         <= 5'h00;
      ctrl_o      <= CTRL_RST;
      crc_flag    <= 1'b0;
      rd_pend     <= 1'b0;
      rd_act      <= 1'b0;
      out_sh      <= 16'h0000;
      sdo_q       <= 1'b0;
      alert_oe_q  <= 1'b0;
      range_sel_o <= 4'h0;
      ovr_volt_o  <= 1'b0;
      ovr_curr_o  <= 1'b0;
      span_pct_o  <= SPAN_NORM_PCT;
      frame_ok_o  <= 1'b0;
      crc_err_o   <= 1'b0;
    end else if (ce_i) begin
      shreg       <= next_shreg;
      cnt         <= next_cnt;
      ctrl_o      <= next_ctrl;
      crc_flag    <= next_crc_flag;
      rd_pend     <= next_rd_pend;
      rd_act      <= next_rd_act;
      out_sh      <= next_out_sh;
      sdo_q       <= next_sdo;
      alert_oe_q  <= next_alert_oe;
      range_sel_o <= next_range;
      ovr_volt_o  <= next_ovr_volt;
      ovr_curr_o  <= next_ovr_curr;
      span_pct_o  <= next_span;
      frame_ok_o  <= next_frame_ok;
      crc_err_o   <= next_crc_err;
    end
  end

  // open drain: the pin only ever pulls low
  assign link.alert_drv = 1'b0;
  assign link.alert_oe  = alert_oe_q;
  assign link.sdo       = sdo_q;
endmodule
`default_nettype wire

//--- sfc_host.sv
// host end: wishbone command registers, serial frame sender with optional check byte, readback, irq
`timescale 1ns/100ps
`default_nettype none
module sfc_host (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [sfc_pkg::WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  output logic      [31:0]                  wb_dat_o,
  output logic                              wb_ack_o,
  output logic                              irq_o,
  sfc_link_if.host                          link
);
  import sfc_pkg::*;

  typedef enum logic [4:0] {
    H_IDLE  = 5'b00001,
    H_SETUP = 5'b00010,
    H_HIGH  = 5'b00100,
    H_LOW   = 5'b01000,
    H_GAP   = 5'b10000
  } sfc_hstate_t;

  sfc_hstate_t state, next_state;
  logic [TMR_W-1:0] tmr, next_tmr;
  logic [4:0]  bitcnt, next_bitcnt;
  logic [4:0]  nbits, next_nbits;
  logic [23:0] sh, next_sh;
  logic [15:0] word, next_word;
  logic        crc_en, next_crc_en;
  logic [15:0] rb, next_rb;
  logic [1:0]  irq_st, next_irq_st;
  logic [1:0]  irq_mask, next_irq_mask;
  logic        sclk_q, next_sclk;
  logic        sdi_q, next_sdi;
  logic        sync_q, next_sync;
  logic        next_ack;
  logic [31:0] next_dat;
  logic        next_irq;
  logic [1:0]  meta, pin;
  logic [7:0]  crc_val;
  logic        crc_clr;
  logic        crc_shift;
  logic        wr;
  logic        tmr_done;
  logic [4:0]  idx_n;
  logic [23:0] sh_sh;
  logic [31:0] wmask;
  logic [31:0] cmd_val;

  // readback and alert come from the far end: two flops each
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 2'h2;
      pin  <= 2'h2;
    end else if (ce_i) begin
      meta <= {link.alert, link.sdo};
      pin  <= meta;
    end
  end

  sfc_crc8 u_crc (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .clear_i (crc_clr),
    .shift_i (crc_shift),
    .bit_i   (sdi_q),
    .crc_o   (crc_val)
  );

  // writes land at the edge where the master sees ack
  assign wr       = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign tmr_done = (tmr == '0);
  assign idx_n    = 5'(bitcnt + 5'h01);
  assign crc_clr  = (state == H_IDLE);
  assign crc_shift = (state == H_HIGH) & tmr_done & (bitcnt < BASIC_BITS);
  assign cmd_val  = {15'h0000, crc_en, word};

  // byte lanes mask the command write
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{wb_sel_i[i]}};
    end
  end

  // register file and frame sequencer
  always_comb begin
    next_state    = state;
    next_tmr      = tmr_done ? tmr : TMR_W'(tmr - 1'b1);
    next_bitcnt   = bitcnt;
    next_nbits    = nbits;
    next_sh       = sh;
    next_word     = word;
    next_crc_en   = crc_en;
    next_rb       = rb;
    next_irq_st   = irq_st;
    next_irq_mask = irq_mask;
    next_sclk     = sclk_q;
    next_sdi      = sdi_q;
    next_sync     = sync_q;
    sh_sh         = {sh[22:0], 1'b0};
    if (idx_n == BASIC_BITS) begin
      sh_sh[23:16] = crc_val;
    end
    if (wr & (wb_adr_i == REG_CMD)) begin
      {next_crc_en, next_word} = 17'((cmd_val & ~wmask) | (wb_dat_i & wmask));
    end
    if (wr & (wb_adr_i == REG_MASK) & wb_sel_i[0]) begin
      next_irq_mask = wb_dat_i[1:0];
    end
    if (wr & (wb_adr_i == REG_IRQ) & wb_sel_i[0]) begin
      next_irq_st = irq_st & ~wb_dat_i[1:0];
    end
    if (~pin[1]) begin
      next_irq_st[IRQ_ALERT] = 1'b1;                           // set beats clear
    end
    unique case (state)
      H_IDLE: begin
        // a go while busy is simply not seen here
        if (wr & (wb_adr_i == REG_CMD) & wb_sel_i[3] & wb_dat_i[CMD_GO_BIT]) begin
          next_sh     = {next_word, 8'h00};
          next_nbits  = next_crc_en ? FRAME_BITS : BASIC_BITS;
          next_bitcnt = 5'h00;
          next_sync   = 1'b0;
          next_sdi    = next_word[15];
          next_tmr    = TMR_W'(SCLK_HALF_CYC - 1);
          next_state  = H_SETUP;
        end
      end
      H_SETUP: begin
        if (tmr_done) begin
          next_sclk  = 1'b1;
          next_tmr   = TMR_W'(SCLK_HALF_CYC - 1);
          next_state = H_HIGH;
        end
      end
      H_HIGH: begin
        // falling edge: data has been steady for a half period
        if (tmr_done) begin
          next_sclk = 1'b0;
          if (bitcnt < BASIC_BITS) begin
            next_rb = {rb[14:0], pin[0]};
          end
          next_tmr   = TMR_W'(SCLK_HALF_CYC - 1);
          next_state = H_LOW;
        end
      end
      H_LOW: begin
        if (tmr_done) begin
          next_bitcnt = idx_n;
          next_tmr    = TMR_W'(SCLK_HALF_CYC - 1);
          if (idx_n == nbits) begin
            next_sync  = 1'b1;
            next_sdi   = 1'b0;
            next_state = H_GAP;
          end else begin
            next_sh    = sh_sh;
            next_sdi   = sh_sh[23];
            next_sclk  = 1'b1;
            next_state = H_HIGH;
          end
        end
      end
      H_GAP: begin
        if (tmr_done) begin
          next_irq_st[IRQ_DONE] = 1'b1;
          next_state = H_IDLE;
        end
      end
    endcase
  end

  // bus answer one cycle after the request, dropped again the next cycle even while the strobe stays up
  always_comb begin
    next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_dat = 32'h00000000;
    unique case (wb_adr_i)
      REG_CMD:  next_dat = cmd_val;
      REG_STAT: next_dat = {rb, 14'h0000, ~pin[1], (state != H_IDLE)};
      REG_IRQ:  next_dat = {30'h00000000, irq_st};
      REG_MASK: next_dat = {30'h00000000, irq_mask};
      default:  next_dat = 32'h00000000;
    endcase
    next_irq = |(next_irq_st & next_irq_mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= H_IDLE;
      tmr      <= '0;
      bitcnt   <= 5'h00;
      nbits    <= BASIC_BITS;
      sh       <= 24'h000000;
      word     <= 16'h0000;
      crc_en   <= 1'b0;
      rb       <= 16'h0000;
      irq_st   <= 2'h0;
      irq_mask <= 2'h0;
      sclk_q   <= 1'b0;
      sdi_q    <= 1'b0;
      sync_q   <= 1'b1;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      irq_o    <= 1'b0;
    end else if (ce_i) begin
      state    <= next_state;
      tmr      <= next_tmr;
      bitcnt   <= next_bitcnt;
      nbits    <= next_nbits;
      sh       <= next_sh;
      word     <= next_word;
      crc_en   <= next_crc_en;
      rb       <= next_rb;
      irq_st   <= next_irq_st;
      irq_mask <= next_irq_mask;
      sclk_q   <= next_sclk;
      sdi_q    <= next_sdi;
      sync_q   <= next_sync;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      irq_o    <= next_irq;
    end
  end

  assign link.sclk   = sclk_q;
  assign link.sdi    = sdi_q;
  assign link.sync_n = sync_q;
endmodule
`default_nettype wire

//--- sfc_chk.sv
// link assertions beside the host-to-device interface
`timescale 1ns/100ps
`default_nettype none
module sfc_chk (
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       sclk,
  input wire logic                       sdi,
  input wire logic                       sync_n,
  input wire logic                       alert_oe,
  input wire logic                       alert,
  input wire logic                       hw_mode_i,
  input wire logic                       over_temp_i,
  input wire logic                       frame_ok_o,
  input wire logic                       crc_err_o,
  input wire logic [sfc_pkg::CTRL_W-1:0] ctrl_o,
  input wire logic                       raw_err_i,
  input wire logic                       raw_alert_oe_i
);
  import sfc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // setup phase after select falls, then one high phase of the serial clock
  sequence s_setup;
    !sclk [*8];
  endsequence
  sequence s_high;
    sclk [*8] ##1 !sclk;
  endsequence
  AST_SYNC_IDLE: assert property (sync_n |-> !sclk) else $error("clock outside frame");
  AST_SETUP: assert property ($fell(sync_n) |-> s_setup) else $error("short setup");
  AST_HIGH: assert property ($rose(sclk) |-> s_high) else $error("bad high phase");
  // data may only move with select falling or the rising clock, so the falling edge sees it settled
  AST_SDI_HOLD: assert property (!sync_n && !$fell(sync_n) && !$rose(sclk) |-> $stable(sdi))
    else $error("data moved mid phase");
  AST_RESULT: assert property (frame_ok_o || crc_err_o |-> sync_n && $past(sync_n, 3))
    else $error("result before frame end");
  AST_ONE_RESULT: assert property (!(frame_ok_o && crc_err_o)) else $error("ok and error");
  AST_CTRL_FRAMED: assert property ($changed(ctrl_o) |-> sync_n) else $error("ctrl mid frame");
  // the host's check byte, when appended, is always good, so the error path is watched on the raw-driven device
  AST_ERR_ALERT: assert property (raw_err_i |-> ##[1:3] raw_alert_oe_i) else $error("no alert");
  AST_FAULT_ALERT: assert property ((over_temp_i && !hw_mode_i) [*8] |-> !alert)
    else $error("fault not on alert");
endmodule
`default_nettype wire

//--- serial_frame_crc_checker_test.sv
// self-checking bench: host and device joined, plus a raw-driven second device
`timescale 1ns/100ps
`default_nettype none
module serial_frame_crc_checker_test;
  import sfc_pkg::*;
  logic        clk_i, rst_i, ce, cyc, stb, we, hw, ot, co, vs, irq, ack, ovv, ovc, fok, cerr, cerr2;
  logic [3:0]  adr, pins, rsel;
  logic [31:0] wdat, rdat, q;
  logic [12:0] ctrl1, ctrl2;
  logic [7:0]  span;
  logic [15:0] rb, v;
  int          errors, comparisons, seed;
  sfc_link_if l1 ();
  sfc_link_if l2 ();
  sfc_host sfc_host_i (.clk_i, .rst_i, .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .link(l1));
  sfc_dev sfc_dev_i (.clk_i, .rst_i, .ce_i(ce), .link(l1), .hw_mode_i(hw), .range_pins_i(pins), .over_temp_i(ot),
    .current_open_i(co), .voltage_short_i(vs), .ctrl_o(ctrl1), .range_sel_o(rsel), .ovr_volt_o(ovv),
    .ovr_curr_o(ovc), .span_pct_o(span), .frame_ok_o(fok), .crc_err_o(cerr));
  // second device faces the bench directly so that broken frames can be sent
  sfc_dev sfc_dev_i2 (.clk_i, .rst_i, .ce_i(ce), .link(l2), .hw_mode_i(1'b0), .range_pins_i(pins),
    .over_temp_i(1'b0), .current_open_i(1'b0), .voltage_short_i(1'b0), .ctrl_o(ctrl2), .range_sel_o(),
    .ovr_volt_o(), .ovr_curr_o(), .span_pct_o(), .frame_ok_o(), .crc_err_o(cerr2));
  sfc_chk sfc_chk_i (.clk_i, .rst_i, .sclk(l1.sclk), .sdi(l1.sdi), .sync_n(l1.sync_n), .alert_oe(l1.alert_oe),
    .alert(l1.alert), .hw_mode_i(hw), .over_temp_i(ot), .frame_ok_o(fok), .crc_err_o(cerr), .ctrl_o(ctrl1),
    .raw_err_i(cerr2), .raw_alert_oe_i(l2.alert_oe));
  // clock generator
  initial begin
    clk_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
  end
  task automatic conclude;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // classic wishbone cycle; the watchdog ends a wait for an ack that never comes
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // one frame through the host, done interrupt awaited then cleared
  task automatic send(input logic [15:0] w, input logic c);
    int t;
    t = 0;
    wb(1'b1, REG_CMD, {1'b1, 14'h0, c, w});
    while (irq !== 1'b1 && t < 2000) begin
      @(posedge clk_i);
      t++;
    end
    wb(1'b1, REG_IRQ, 32'h1);
    if (t >= 2000) errors++;
  endtask
  // raw frame of n bits to the second device; readback caught at each falling clock
  task automatic raw(input logic [23:0] f, input int n);
    @(posedge clk_i);
    l2.sync_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int i = n - 1; i >= 0; i--) begin
      l2.sdi <= f[i];
      l2.sclk <= 1'b1;
      repeat (8) @(posedge clk_i);
      l2.sclk <= 1'b0;
      rb = {rb[14:0], l2.sdo};
      repeat (8) @(posedge clk_i);
    end
    l2.sync_n <= 1'b1;
    l2.sdi <= ~l2.sdi;
    repeat (12) @(posedge clk_i);
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction
  // expected overrange flags and span for a range code
  function automatic logic [9:0] ovr_of(input logic [3:0] r);
    if (r[3] && !r[2]) return {2'b10, SPAN_VOLT_PCT};
    if (r[3] && r[1:0] != CUR_BIPOLAR_IDX) return {2'b01, SPAN_CURR_PCT};
    return {2'b00, SPAN_NORM_PCT};
  endfunction
  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    conclude;
  end
  initial begin
    {rst_i, ce, seed} = {2'b11, 32'h7B8D};
    {cyc, stb, we, adr, wdat, hw, pins, ot, co, vs, rb} = '0;
    {l2.sclk, l2.sdi, l2.sync_n} = 3'h1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, REG_MASK, 32'h1);
    wb(1'b0, 4'h2, 32'hFFFFFFFF);
    chk(q, 32'h0);
    // every range code, odd codes with check byte, even codes without
    for (int k = 0; k < 16; k++) begin
      v = 16'($random(seed));
      v[15:13] = ADDR_CTRL;
      v[CTRL_RANGE_LSB +: RANGE_W] = k[3:0];
      send(v, k[0]);
      chk(ctrl1, v[12:0]);
      chk({rsel, ovv, ovc, span}, {k[3:0], ovr_of(k[3:0])});
    end
    send({3'h5, 13'h0ABC}, 1'b1);
    chk(ctrl1, v[12:0]);
    // hardware mode: pins pick range, alert held off
    hw <= 1'b1;
    pins <= 4'hB;
    ot <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk({rsel, l1.alert}, {4'hB, 1'b1});
    hw <= 1'b0;
    co <= 1'($random(seed));
    vs <= 1'($random(seed));
    repeat (10) @(posedge clk_i);
    chk(l1.alert, 1'b0);
    send({ADDR_RDSTAT, 13'h0}, 1'b0);
    send(16'hE000, 1'b0);
    wb(1'b0, REG_STAT, 32'h0);
    chk({q[31:16], q[1:0]}, {3'b001, v[12:4], 1'b0, 1'b1, co, vs, 1'b1, 1'b0});
    wb(1'b0, REG_IRQ, 32'h0);
    chk({q[1], irq}, 2'b10);
    {ot, co, vs} <= 3'h0;
    // broken check byte, then a good frame, then a short frame
    raw({16'h0123, crc8(16'h0123) ^ 8'h01}, 24);
    chk({ctrl2, l2.alert}, 14'h0);
    raw({16'h1555, crc8(16'h1555)}, 24);
    chk(ctrl2, 13'h1555);
    raw(24'h0AAA50, 20);
    chk(ctrl2, 13'h1555);
    raw(24'h002000, 16);
    raw(24'h00E000, 16);
    chk({rb, l2.alert}, {3'b001, 9'h155, 4'b1000, 1'b1});
    raw(24'h002000, 16);
    raw(24'h00E000, 16);
    chk(rb[3], 1'b0);
    conclude;
  end
endmodule
`default_nettype wire
